// File: include/sdram_mode_pkg.sv
package sdram_mode_pkg;

  localparam int MODE_W    = 12;
  localparam int BANK_W    = 2;
  localparam int COL_W     = 9;
  localparam int BL_LSB    = 0;
  localparam int BL_W      = 3;
  localparam int ORDER_BIT = 3;
  localparam int LAT_LSB   = 4;
  localparam int LAT_W     = 3;
  localparam int OPM_LSB   = 7;
  localparam int OPM_W     = 2;
  localparam int SWR_BIT   = 9;

  localparam logic [BL_W-1:0]  BL_1       = 3'h0;
  localparam logic [BL_W-1:0]  BL_8       = 3'h3;
  localparam logic [BL_W-1:0]  BL_FULL    = 3'h7;
  localparam logic [LAT_W-1:0] CL_1       = 3'h1;
  localparam logic [LAT_W-1:0] CL_2       = 3'h2;
  localparam logic [LAT_W-1:0] CL_3       = 3'h3;
  localparam logic [OPM_W-1:0] OPM_NORMAL = 2'h0;

  // Command code is {ras_n, cas_n, we_n} while cs_n is low
  localparam logic [2:0] CMD_LMR   = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ  = 3'h5;
  localparam logic [2:0] CMD_BTERM = 3'h6;
  localparam logic [2:0] CMD_NOP   = 3'h7;

  localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;
  localparam logic [COL_W-1:0]  COL_ZERO   = 9'h000;
  localparam logic [COL_W-1:0]  COL_ONE    = 9'h001;
  localparam logic [COL_W-1:0]  COL_ALL    = 9'h1ff;

  // Controller register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  localparam logic [2:0] OPC_LOAD  = 3'h1;
  localparam logic [2:0] OPC_READ  = 3'h2;
  localparam logic [2:0] OPC_WRITE = 3'h3;
  localparam logic [2:0] OPC_TERM  = 3'h4;

  localparam int CNT_W       = 8;
  localparam int BUSY_BIT    = 8;
  localparam int LOADED_BIT  = 9;
  localparam int REFUSED_BIT = 10;

  localparam int MODE_SET_DELAY_NS = 20;
  localparam int CLK_MHZ           = 10;
  localparam int MRD_RAW           = (MODE_SET_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int MRD_CYCLES        = (MRD_RAW < 1) ? 1 : MRD_RAW;

  typedef enum logic {
    B_IDLE = 1'b0,
    B_RUN  = 1'b1
  } burst_state_t;

  typedef enum logic [1:0] {
    C_IDLE   = 2'b00,
    C_MRD    = 2'b01,
    C_WBURST = 2'b10
  } ctl_state_t;

  // Block mask; also the index of the last access in a burst that is not full row
  function automatic logic [COL_W-1:0] blc_mask(input logic [BL_W-1:0] code);
    if (code == BL_FULL) begin
      return COL_ALL;
    end
    return (COL_ONE << code) - COL_ONE;
  endfunction : blc_mask

  function automatic logic bl_ok(input logic [BL_W-1:0] code);
    return (code <= BL_8) || (code == BL_FULL);
  endfunction : bl_ok

  function automatic logic lat_ok(input logic [LAT_W-1:0] code);
    return (code >= CL_1) && (code <= CL_3);
  endfunction : lat_ok

endpackage : sdram_mode_pkg

// File: include/sdram_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdram_link_if #(
  parameter int DATA_W = 32
);
  logic                               cs_n;
  logic                               ras_n;
  logic                               cas_n;
  logic                               we_n;
  logic [sdram_mode_pkg::BANK_W-1:0]  ba;
  logic [sdram_mode_pkg::MODE_W-1:0]  addr;
  logic [DATA_W-1:0]                  ctl_dq;
  logic                               ctl_dq_oe;
  logic [DATA_W-1:0]                  dev_dq;
  logic                               dev_dq_oe;

  modport device (
    input  cs_n, ras_n, cas_n, we_n, ba, addr, ctl_dq, ctl_dq_oe,
    output dev_dq, dev_dq_oe
  );

  modport controller (
    output cs_n, ras_n, cas_n, we_n, ba, addr, ctl_dq, ctl_dq_oe,
    input  dev_dq, dev_dq_oe
  );
endinterface : sdram_link_if
`default_nettype wire

// File: rtl/sdram_mode_dev.sv
// Function
// - Configuration changes only on load-mode command
// - Fixed mode bit field layout, rest reserved
// - Load only with banks idle, then wait
// - Lengths 1,2,4,8; full row sequential
// - Full row runs until burst terminate
// - Burst wraps inside aligned column block
// - Full row wraps from last column
// - Sequential adds counter, interleaved XORs it
// - Length one: single column, order ignored
// - Read latency one, two or three
// - Drive from edge n+m-1, valid n+m
// - Only normal operating mode is used
// - Single-write bit limits writes to one
// - Reserved encodings are never programmed
// - Mode value taken from address pins
// - No command before mode-set delay ends
// - Mode unknown until first load
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_dev #(
  parameter int DATA_W = 32
) (
  input  wire logic                               clock,
  input  wire logic                               rst_n,
  sdram_link_if.device                            link,
  output var  logic [sdram_mode_pkg::MODE_W-1:0]  mode_value,
  output var  logic                               mode_loaded,
  output var  logic [sdram_mode_pkg::COL_W-1:0]   access_col,
  output var  logic                               access_valid,
  output var  logic                               access_write
);

  localparam int COLS = 1 << sdram_mode_pkg::COL_W;

  logic [DATA_W-1:0]                   mem [0:COLS-1];

  sdram_mode_pkg::burst_state_t        state;
  sdram_mode_pkg::burst_state_t        next_state;
  logic [sdram_mode_pkg::COL_W-1:0]    start;
  logic [sdram_mode_pkg::COL_W-1:0]    next_start;
  logic [sdram_mode_pkg::COL_W-1:0]    cnt;
  logic [sdram_mode_pkg::COL_W-1:0]    next_cnt;
  logic [sdram_mode_pkg::BL_W-1:0]     run_blc;
  logic [sdram_mode_pkg::BL_W-1:0]     next_run_blc;
  logic                                run_write;
  logic                                next_run_write;
  logic [sdram_mode_pkg::MODE_W-1:0]   next_mode_value;
  logic                                next_mode_loaded;
  logic [sdram_mode_pkg::COL_W-1:0]    next_access_col;
  logic                                next_access_valid;
  logic                                next_access_write;
  logic [DATA_W-1:0]                   pipe_d0;
  logic [DATA_W-1:0]                   pipe_d1;
  logic                                pipe_v0;
  logic                                pipe_v1;
  logic [DATA_W-1:0]                   next_pipe_d0;
  logic [DATA_W-1:0]                   next_pipe_d1;
  logic                                next_pipe_v0;
  logic                                next_pipe_v1;
  logic [DATA_W-1:0]                   next_dq;
  logic                                next_dq_oe;

  logic [2:0]                          cmd;
  logic                                is_lmr;
  logic                                is_rw;
  logic                                is_term;
  logic                                wr_cmd;
  logic                                cfg_ok;
  logic [sdram_mode_pkg::BL_W-1:0]     mode_blc;
  logic [sdram_mode_pkg::LAT_W-1:0]    mode_lat;
  logic [sdram_mode_pkg::OPM_W-1:0]    mode_opm;
  logic                                mode_order;
  logic                                mode_swr;
  logic [sdram_mode_pkg::BL_W-1:0]     eff_blc;
  logic                                acc_en;
  logic                                acc_wr;
  logic [sdram_mode_pkg::COL_W-1:0]    acc_start;
  logic [sdram_mode_pkg::COL_W-1:0]    acc_idx;
  logic [sdram_mode_pkg::BL_W-1:0]     acc_blc;
  logic [sdram_mode_pkg::COL_W-1:0]    acc_col;
  logic [DATA_W-1:0]                   rd_word;

  // Column of access idx within the burst
  function automatic logic [sdram_mode_pkg::COL_W-1:0] burst_col(
    input logic [sdram_mode_pkg::COL_W-1:0] s,
    input logic [sdram_mode_pkg::COL_W-1:0] idx,
    input logic [sdram_mode_pkg::BL_W-1:0]  blc,
    input logic                             interleave
  );
    logic [sdram_mode_pkg::COL_W-1:0] mask;
    logic [sdram_mode_pkg::COL_W-1:0] off;
    mask = sdram_mode_pkg::blc_mask(blc);
    // Interleave is undefined for a full row, so it stays sequential
    if (interleave && (blc != sdram_mode_pkg::BL_FULL)) begin
      off = (s ^ idx) & mask;
    end else begin
      off = (s + idx) & mask;
    end
    return (s & ~mask) | off;
  endfunction : burst_col

  always_comb begin
    mode_blc   = mode_value[sdram_mode_pkg::BL_LSB +: sdram_mode_pkg::BL_W];
    mode_order = mode_value[sdram_mode_pkg::ORDER_BIT];
    mode_lat   = mode_value[sdram_mode_pkg::LAT_LSB +: sdram_mode_pkg::LAT_W];
    mode_opm   = mode_value[sdram_mode_pkg::OPM_LSB +: sdram_mode_pkg::OPM_W];
    mode_swr   = mode_value[sdram_mode_pkg::SWR_BIT];
    cmd        = {link.ras_n, link.cas_n, link.we_n};
    wr_cmd     = (cmd == sdram_mode_pkg::CMD_WRITE);
    // Bursts only with a loaded, normal-mode setup of legal length; latency is checked for reads only
    cfg_ok     = mode_loaded && (mode_opm == sdram_mode_pkg::OPM_NORMAL)
                 && sdram_mode_pkg::bl_ok(mode_blc)
                 && (wr_cmd || sdram_mode_pkg::lat_ok(mode_lat));
    is_lmr     = !link.cs_n && (cmd == sdram_mode_pkg::CMD_LMR);
    is_rw      = !link.cs_n && cfg_ok
                 && (wr_cmd || (cmd == sdram_mode_pkg::CMD_READ));
    is_term    = !link.cs_n && (cmd == sdram_mode_pkg::CMD_BTERM);
    eff_blc    = (wr_cmd && mode_swr) ? sdram_mode_pkg::BL_1 : mode_blc;
  end

  always_comb begin
    next_state        = state;
    next_start        = start;
    next_cnt          = cnt;
    next_run_blc      = run_blc;
    next_run_write    = run_write;
    next_mode_value   = mode_value;
    next_mode_loaded  = mode_loaded;
    acc_en            = 1'b0;
    acc_wr            = run_write;
    acc_start         = start;
    acc_idx           = cnt;
    acc_blc           = run_blc;
    if (is_lmr) begin
      next_mode_value  = link.addr;
      next_mode_loaded = 1'b1;
    end
    if (is_rw) begin
      // A new command cuts off any burst still running
      acc_en         = 1'b1;
      acc_wr         = wr_cmd;
      acc_start      = link.addr[sdram_mode_pkg::COL_W-1:0];
      acc_idx        = sdram_mode_pkg::COL_ZERO;
      acc_blc        = eff_blc;
      next_start     = link.addr[sdram_mode_pkg::COL_W-1:0];
      next_cnt       = sdram_mode_pkg::COL_ONE;
      next_run_blc   = eff_blc;
      next_run_write = wr_cmd;
      next_state     = (eff_blc == sdram_mode_pkg::BL_1)
                       ? sdram_mode_pkg::B_IDLE : sdram_mode_pkg::B_RUN;
    end else if (is_term) begin
      next_state = sdram_mode_pkg::B_IDLE;
    end else begin
      unique case (state)
        sdram_mode_pkg::B_IDLE: begin
          next_state = sdram_mode_pkg::B_IDLE;
        end
        sdram_mode_pkg::B_RUN: begin
          acc_en   = 1'b1;
          next_cnt = cnt + sdram_mode_pkg::COL_ONE;
          // Full row never ends by count
          if ((run_blc != sdram_mode_pkg::BL_FULL)
              && (cnt == sdram_mode_pkg::blc_mask(run_blc))) begin
            next_state = sdram_mode_pkg::B_IDLE;
          end
        end
      endcase
    end
    acc_col           = burst_col(acc_start, acc_idx, acc_blc, mode_order);
    next_access_col   = acc_col;
    next_access_valid = acc_en;
    next_access_write = acc_en && acc_wr;
  end

  // Read path: latency one loads the pins on the command edge itself
  always_comb begin
    rd_word      = mem[acc_col];
    next_pipe_d0 = rd_word;
    next_pipe_v0 = acc_en && !acc_wr;
    next_pipe_d1 = pipe_d0;
    next_pipe_v1 = pipe_v0;
    if (mode_lat == sdram_mode_pkg::CL_1) begin
      next_dq    = rd_word;
      next_dq_oe = acc_en && !acc_wr;
    end else if (mode_lat == sdram_mode_pkg::CL_2) begin
      next_dq    = pipe_d0;
      next_dq_oe = pipe_v0;
    end else begin
      next_dq    = pipe_d1;
      next_dq_oe = pipe_v1;
    end
  end

  always_ff @(posedge clock) begin
    // Nothing is stored for a word the controller does not drive
    if (acc_en && acc_wr && link.ctl_dq_oe) begin
      mem[acc_col] <= link.ctl_dq;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state          <= sdram_mode_pkg::B_IDLE;
      start          <= sdram_mode_pkg::COL_ZERO;
      cnt            <= sdram_mode_pkg::COL_ZERO;
      run_blc        <= sdram_mode_pkg::BL_1;
      run_write      <= 1'b0;
      mode_value     <= sdram_mode_pkg::MODE_RESET;
      mode_loaded    <= 1'b0;
      access_col     <= sdram_mode_pkg::COL_ZERO;
      access_valid   <= 1'b0;
      access_write   <= 1'b0;
      pipe_d0        <= '0;
      pipe_d1        <= '0;
      pipe_v0        <= 1'b0;
      pipe_v1        <= 1'b0;
      link.dev_dq    <= '0;
      link.dev_dq_oe <= 1'b0;
    end else begin
      state          <= next_state;
      start          <= next_start;
      cnt            <= next_cnt;
      run_blc        <= next_run_blc;
      run_write      <= next_run_write;
      mode_value     <= next_mode_value;
      mode_loaded    <= next_mode_loaded;
      access_col     <= next_access_col;
      access_valid   <= next_access_valid;
      access_write   <= next_access_write;
      pipe_d0        <= next_pipe_d0;
      pipe_d1        <= next_pipe_d1;
      pipe_v0        <= next_pipe_v0;
      pipe_v1        <= next_pipe_v1;
      link.dev_dq    <= next_dq;
      link.dev_dq_oe <= next_dq_oe;
    end
  end

endmodule : sdram_mode_dev
`default_nettype wire

// File: rtl/sdram_mode_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_ctl #(
  parameter int DATA_W     = 32,
  parameter int MRD_CYCLES = sdram_mode_pkg::MRD_CYCLES
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output var  logic [31:0]        reg_rdata,
  sdram_link_if.controller        link
);

  localparam int AW = sdram_mode_pkg::MODE_W + sdram_mode_pkg::BANK_W;
  localparam int CW = sdram_mode_pkg::CNT_W;

  sdram_mode_pkg::ctl_state_t          state;
  sdram_mode_pkg::ctl_state_t          next_state;
  logic [AW-1:0]                       addr_reg;
  logic [AW-1:0]                       next_addr_reg;
  logic [DATA_W-1:0]                   wdata_reg;
  logic [DATA_W-1:0]                   next_wdata_reg;
  logic [DATA_W-1:0]                   rdata_reg;
  logic [DATA_W-1:0]                   next_rdata_reg;
  logic [CW-1:0]                       rd_count;
  logic [CW-1:0]                       next_rd_count;
  logic [sdram_mode_pkg::MODE_W-1:0]   shadow;
  logic [sdram_mode_pkg::MODE_W-1:0]   next_shadow;
  logic                                loaded;
  logic                                next_loaded;
  logic                                refused;
  logic                                next_refused;
  logic [CW-1:0]                       wait_cnt;
  logic [CW-1:0]                       next_wait_cnt;
  logic [sdram_mode_pkg::COL_W-1:0]    left;
  logic [sdram_mode_pkg::COL_W-1:0]    next_left;
  logic                                full_wr;
  logic                                next_full_wr;
  logic [2:0]                          next_cmd;
  logic [sdram_mode_pkg::BANK_W-1:0]   next_ba;
  logic [sdram_mode_pkg::MODE_W-1:0]   next_pin_addr;
  logic [DATA_W-1:0]                   next_dq;
  logic                                next_dq_oe;
  logic [31:0]                         next_reg_rdata;
  logic [2:0]                          opc;
  logic [sdram_mode_pkg::MODE_W-1:0]   new_mode;
  logic [sdram_mode_pkg::BL_W-1:0]     wr_blc;
  logic                                ctrl_wr;

  always_comb begin
    next_state     = state;
    next_addr_reg  = addr_reg;
    next_wdata_reg = wdata_reg;
    next_shadow    = shadow;
    next_loaded    = loaded;
    next_refused   = refused;
    next_wait_cnt  = wait_cnt;
    next_left      = left;
    next_full_wr   = full_wr;
    next_cmd       = sdram_mode_pkg::CMD_NOP;
    next_ba        = addr_reg[AW-1 -: sdram_mode_pkg::BANK_W];
    next_pin_addr  = addr_reg[sdram_mode_pkg::MODE_W-1:0];
    next_dq        = wdata_reg;
    next_dq_oe     = 1'b0;
    opc            = reg_wdata[2:0];
    new_mode       = addr_reg[sdram_mode_pkg::MODE_W-1:0];
    wr_blc         = shadow[sdram_mode_pkg::SWR_BIT] ? sdram_mode_pkg::BL_1
                     : shadow[sdram_mode_pkg::BL_LSB +: sdram_mode_pkg::BL_W];
    ctrl_wr        = reg_wr && (reg_addr == sdram_mode_pkg::REG_CTRL);
    if (reg_wr && (reg_addr == sdram_mode_pkg::REG_ADDR)) begin
      next_addr_reg = reg_wdata[AW-1:0];
    end
    if (reg_wr && (reg_addr == sdram_mode_pkg::REG_WDATA)) begin
      next_wdata_reg = reg_wdata[DATA_W-1:0];
    end
    // Status read clears first, so a refusal below in the same cycle wins
    if (reg_rd && (reg_addr == sdram_mode_pkg::REG_STATUS)) begin
      next_refused = 1'b0;
    end
    unique case (state)
      sdram_mode_pkg::C_IDLE: begin
        next_state = sdram_mode_pkg::C_IDLE;
      end
      sdram_mode_pkg::C_MRD: begin
        next_wait_cnt = wait_cnt - 8'h01;
        if (wait_cnt <= 8'h01) begin
          next_state = sdram_mode_pkg::C_IDLE;
        end
      end
      sdram_mode_pkg::C_WBURST: begin
        next_dq_oe = 1'b1;
        next_left  = left - sdram_mode_pkg::COL_ONE;
        if (!full_wr && (left == sdram_mode_pkg::COL_ONE)) begin
          next_state = sdram_mode_pkg::C_IDLE;
        end
      end
    endcase
    if (ctrl_wr) begin
      if (state == sdram_mode_pkg::C_MRD) begin
        next_refused = 1'b1;
      end else if (opc == sdram_mode_pkg::OPC_LOAD) begin
        // Refuse reserved setups instead of sending them
        if ((state != sdram_mode_pkg::C_IDLE)
            || (new_mode[sdram_mode_pkg::OPM_LSB +: sdram_mode_pkg::OPM_W]
                != sdram_mode_pkg::OPM_NORMAL)
            || !sdram_mode_pkg::bl_ok(new_mode[sdram_mode_pkg::BL_LSB +: sdram_mode_pkg::BL_W])
            || !sdram_mode_pkg::lat_ok(
                  new_mode[sdram_mode_pkg::LAT_LSB +: sdram_mode_pkg::LAT_W])) begin
          next_refused = 1'b1;
        end else begin
          next_cmd      = sdram_mode_pkg::CMD_LMR;
          next_shadow   = new_mode;
          next_loaded   = 1'b1;
          next_state    = sdram_mode_pkg::C_MRD;
          next_wait_cnt = 8'(MRD_CYCLES);
          next_dq_oe    = 1'b0;
        end
      end else if (((opc == sdram_mode_pkg::OPC_READ) || (opc == sdram_mode_pkg::OPC_WRITE))
                   && !loaded) begin
        next_refused = 1'b1;
      end else if (opc == sdram_mode_pkg::OPC_READ) begin
        next_cmd   = sdram_mode_pkg::CMD_READ;
        next_state = sdram_mode_pkg::C_IDLE;
        next_dq_oe = 1'b0;
      end else if (opc == sdram_mode_pkg::OPC_WRITE) begin
        next_cmd     = sdram_mode_pkg::CMD_WRITE;
        next_dq      = next_wdata_reg;
        next_dq_oe   = 1'b1;
        next_left    = sdram_mode_pkg::blc_mask(wr_blc);
        next_full_wr = (wr_blc == sdram_mode_pkg::BL_FULL);
        next_state   = (wr_blc == sdram_mode_pkg::BL_1)
                       ? sdram_mode_pkg::C_IDLE : sdram_mode_pkg::C_WBURST;
      end else if (opc == sdram_mode_pkg::OPC_TERM) begin
        next_cmd   = sdram_mode_pkg::CMD_BTERM;
        next_state = sdram_mode_pkg::C_IDLE;
        next_dq_oe = 1'b0;
      end
    end
  end

  always_comb begin
    next_rdata_reg = rdata_reg;
    next_rd_count  = rd_count;
    if (link.dev_dq_oe) begin
      next_rdata_reg = link.dev_dq;
      next_rd_count  = rd_count + 8'h01;
    end
    next_reg_rdata = 32'h0000_0000;
    if (reg_rd && (reg_addr == sdram_mode_pkg::REG_RDATA)) begin
      next_reg_rdata = 32'(rdata_reg);
    end else if (reg_rd && (reg_addr == sdram_mode_pkg::REG_STATUS)) begin
      next_reg_rdata[CW-1:0]                     = rd_count;
      next_reg_rdata[sdram_mode_pkg::BUSY_BIT]    = (state != sdram_mode_pkg::C_IDLE);
      next_reg_rdata[sdram_mode_pkg::LOADED_BIT]  = loaded;
      next_reg_rdata[sdram_mode_pkg::REFUSED_BIT] = refused;
    end else if (reg_rd && (reg_addr == sdram_mode_pkg::REG_ADDR)) begin
      next_reg_rdata = 32'(addr_reg);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state          <= sdram_mode_pkg::C_IDLE;
      addr_reg       <= '0;
      wdata_reg      <= '0;
      rdata_reg      <= '0;
      rd_count       <= '0;
      shadow         <= sdram_mode_pkg::MODE_RESET;
      loaded         <= 1'b0;
      refused        <= 1'b0;
      wait_cnt       <= '0;
      left           <= sdram_mode_pkg::COL_ZERO;
      full_wr        <= 1'b0;
      reg_rdata      <= 32'h0000_0000;
      link.cs_n      <= 1'b1;
      {link.ras_n, link.cas_n, link.we_n} <= sdram_mode_pkg::CMD_NOP;
      link.ba        <= '0;
      link.addr      <= '0;
      link.ctl_dq    <= '0;
      link.ctl_dq_oe <= 1'b0;
    end else begin
      state          <= next_state;
      addr_reg       <= next_addr_reg;
      wdata_reg      <= next_wdata_reg;
      rdata_reg      <= next_rdata_reg;
      rd_count       <= next_rd_count;
      shadow         <= next_shadow;
      loaded         <= next_loaded;
      refused        <= next_refused;
      wait_cnt       <= next_wait_cnt;
      left           <= next_left;
      full_wr        <= next_full_wr;
      reg_rdata      <= next_reg_rdata;
      link.cs_n      <= 1'b0;
      {link.ras_n, link.cas_n, link.we_n} <= next_cmd;
      link.ba        <= next_ba;
      link.addr      <= next_pin_addr;
      link.ctl_dq    <= next_dq;
      link.ctl_dq_oe <= next_dq_oe;
    end
  end

endmodule : sdram_mode_ctl
`default_nettype wire

// File: tb/sdram_mode_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_properties (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [11:0] addr,
  input wire logic        dev_dq_oe
);
  logic [11:0] mode, next_mode;
  logic        ld, next_ld;
  wire  [2:0]  c = cs_n ? 3'h7 : {ras_n, cas_n, we_n};
  always_comb begin
    next_mode = (c == 3'h0) ? addr : mode;
    next_ld = ld | (c == 3'h0);
  end
  always_ff @(posedge clock) begin
    mode <= rst_n ? next_mode : 12'h000;
    ld <= rst_n & next_ld;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_load_then_nop: assert property (c == 3'h0 |=> c == 3'h7)
    else $error("command right after load");
  chk_lat_one: assert property (c == 3'h5 && mode[6:4] == 3'h1 |=> dev_dq_oe)
    else $error("latency one data late");
  chk_lat_three: assert property (c == 3'h5 && mode[6:4] == 3'h3
    |=> (!dev_dq_oe) [*2] ##1 dev_dq_oe) else $error("latency three data misplaced");
  chk_burst_four: assert property ($rose(dev_dq_oe) && mode[2:0] == 3'h2
    |-> dev_dq_oe [*4] ##1 !dev_dq_oe) else $error("burst of four wrong length");
  chk_burst_one: assert property ($rose(dev_dq_oe) && mode[2:0] == 3'h0 |=> !dev_dq_oe)
    else $error("burst of one too long");
  chk_op_normal: assert property (c == 3'h0 |-> addr[8:7] == 2'h0)
    else $error("non-normal operating mode loaded");
  chk_codes_legal: assert property (c == 3'h0 |-> (addr[2:0] < 3'h4 || addr[2:0] == 3'h7)
    && addr[6:4] inside {[3'h1:3'h3]}) else $error("reserved code loaded");
  chk_drive_loaded: assert property (dev_dq_oe |-> ld)
    else $error("data driven before any load");
endmodule : sdram_mode_properties
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clock, rst_n, reg_wr, reg_rd, access_valid, access_write, mode_loaded;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [11:0] mode_value;
  logic [8:0]  access_col;
  logic [9:0]  q[$];
  int          mismatches, comparisons, cyc, n;
  localparam logic [11:0] MD [7] = '{12'h022, 12'h03a, 12'h01b, 12'h018, 12'h221, 12'h023,
                                     12'h027};
  localparam logic [8:0]  ST [7] = '{9'h1, 9'h1, 9'h5, 9'h9, 9'h3, 9'h1fe, 9'h1fe};
  localparam logic [6:0]  WRM = 7'h14;
  sdram_link_if link ();
  sdram_mode_ctl sdram_mode_ctl_i (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .link(link));
  sdram_mode_dev sdram_mode_dev_i (.clock, .rst_n, .link(link), .mode_value, .mode_loaded,
    .access_col, .access_valid, .access_write);
  sdram_mode_properties sdram_mode_properties_i (.clock, .rst_n, .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .addr(link.addr),
    .dev_dq_oe(link.dev_dq_oe));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) if (access_valid) q.push_back({access_write, access_col});
  function automatic logic [8:0] ecol(logic [11:0] m, logic [8:0] s, int i);
    logic [8:0] k;
    k = m[2:0] == 3'h7 ? 9'h1ff : (9'h1 << m[2:0]) - 9'h1;
    return s & ~k | (m[3] && k != 9'h1ff ? s ^ 9'(i) : s + 9'(i)) & k;
  endfunction : ecol
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h2);
    rd(8'h10, v);
    chk(v, 32'h400);
    chk(mode_loaded, 1'b0);
    $display("test refuse done");
    wr(8'h08, 32'h5a3c_96e1);
    for (int i = 0; i < 7; i++) begin
      wr(8'h04, MD[i]);
      wr(8'h00, 32'h1);
      wr(8'h04, ST[i]);
      q.delete();
      wr(8'h00, WRM[i] ? 32'h3 : 32'h2);
      chk(mode_value, MD[i]);
      chk(mode_loaded, 1'b1);
      n = MD[i][2:0] == 3'h7 ? 3 : (WRM[i] && MD[i][9]) ? 1 : 1 << MD[i][2:0];
      // Full row never ends alone, so stop it after a few words
      repeat (4) @(posedge clock);
      if (n == 3) wr(8'h00, 32'h4);
      repeat (12) @(posedge clock);
      // Full row: six accesses from the command edge up to the terminate
      chk(32'(q.size()), n == 3 ? 6 : n);
      for (int j = 0; j < n; j++) begin
        chk(q[j], {WRM[i], ecol(MD[i], ST[i], j)});
      end
      $display("test %0d done", i);
    end
    wr(8'h04, 32'h1a2);
    wr(8'h00, 32'h1);
    rd(8'h10, v);
    chk(v & 32'h600, 32'h600);
    // Read words driven: 4 + 4 + 1 + 8 + 6, controller idle
    chk(v & 32'h1ff, 32'h017);
    chk(mode_value, 12'h027);
    rd(8'h04, v);
    chk(v, 32'h1a2);
    rd(8'h14, v);
    chk(v, 32'h0);
    // Last word read was column 3, written with the data word above
    rd(8'h0c, v);
    chk(v, 32'h5a3c_96e1);
    $display("test regs done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
